// [rtl/humidity_temp_acquisition_ctrl.sv]
// Acquisition control with bus target port, result registers and ready/alarm pin
//
// Functional notes
// - Power-up lands in sleep, waiting for commands.
// - Trigger wakes, converts, stores results, sleeps.
// - One-shot converts only on host trigger.
// - Seven periodic rates chosen by rate field.
// - Periodic mode repeats conversions at selected rate.
// - Reads return register selected by pointer.
// - Pointer advances after every data byte read or written, not after the address or pointer byte.
// - Pin polarity and mode follow control bits.
// - One pin shares ready and alarm duties.
// - Pin can flag threshold crossings.
// - Results are high byte shifted plus low.
// - Result codes are plain unsigned binary.
// - Two low result bits read zero.
// - Restart bit reloads defaults, then self-clears.
`timescale 1ns/100ps
module humidity_temp_acquisition_ctrl
  import acq_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = 7'h40,
  parameter int unsigned RATE_MS [1:NUM_RATES] = '{120000, 60000, 10000, 5000, 1000, 500, 200}
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic ready_alarm_pin,
  output logic heater_enable,
  output logic conv_start,
  output logic conv_temp_en,
  output logic conv_hum_en,
  input wire logic conv_done,
  input wire logic [CODE_W-1:0] conv_temp_code,
  input wire logic [CODE_W-1:0] conv_hum_code,
  input wire logic alarm_enable,
  input wire logic [15:0] temp_alarm_limit,
  input wire logic [15:0] hum_alarm_limit
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic scl_s1_r, scl_s2_r, scl_s3_r;  // Clock line synchroniser and history
  logic sda_s1_r, sda_s2_r, sda_s3_r;  // Data line synchroniser and history
  bus_state_t bus_r;                   // Target port state
  logic [7:0] shift_r;                 // Byte shifter, in and out
  logic [3:0] bitcnt_r;                // Bits of current byte
  logic is_addr_r;                     // Current byte is the address byte
  logic reading_r;                     // Transaction direction is read
  logic first_wr_r;                    // Next written byte is the pointer
  logic sda_oe_r;                      // Line pulled low while high
  logic [7:0] ptr_r;                   // Register pointer
  logic [7:0] ctrl_r;                  // reset_interrupt_control
  logic [7:0] setup_r;                 // measurement_setup
  logic restart_r;                     // One-cycle restart pulse
  logic [15:0] temp_r, hum_r;          // Result registers
  conv_state_t cs_r;                   // Sleep or measure
  logic [31:0] timer_r;                // Periodic countdown
  logic conv_start_r, update_r;        // Start pulse; results just stored
  logic ready_flag_r, alarm_flag_r;    // Sticky pin sources
  logic pin_r;                         // Pin level
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic tx_load, wr_byte, reg_wr, start_conv, done_ok, periodic, result_read, over;
  logic [7:0] rd_data;
  logic [2:0] rate;

  // Convert a rate code into a clock count
  function automatic logic [31:0] rate_cycles(input logic [2:0] code);
    logic [63:0] prod;
    prod = 64'(RATE_MS[int'(code)]) * 64'(CLK_FREQ_KHZ);
    return prod[31:0];
  endfunction

  // Place a code in the high bits and trim to the selected resolution
  function automatic logic [15:0] shape(input logic [CODE_W-1:0] code, input logic [1:0] res);
    logic [CODE_W-1:0] m;
    m = code;
    if (res == RES_11) begin
      m[2:0] = 3'h0;
    end else if (res == RES_9) begin
      m[4:0] = 5'h00;
    end
    return {m, 2'h0};
  endfunction

  // ---------------------------------------------------------------
  // Line synchronisers and bus events
  // ---------------------------------------------------------------
  // Two flops per line, third stage only for edge history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_s3_r} <= 3'h7;
    end else if (ce) begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= {scl_i, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_s3_r} <= {sda_i, sda_s1_r, sda_s2_r};
    end
  end

  assign scl_rise = ce && scl_s2_r && !scl_s3_r;
  assign scl_fall = ce && !scl_s2_r && scl_s3_r;
  assign bus_start = ce && scl_s2_r && scl_s3_r && sda_s3_r && !sda_s2_r;
  assign bus_stop = ce && scl_s2_r && scl_s3_r && !sda_s3_r && sda_s2_r;
  // Byte loaded for the host; byte received from the host
  assign tx_load = scl_fall && !bus_start && !bus_stop && bus_r == IS_ACK && reading_r;
  assign wr_byte = scl_fall && !bus_start && !bus_stop && bus_r == IS_RECV &&
                   bitcnt_r == 4'h8 && !is_addr_r;
  assign reg_wr = wr_byte && !first_wr_r;

  // Read data selected by pointer, unmapped reads as zero
  always_comb begin
    case (ptr_r)
      ADDR_TEMP_LO: rd_data = temp_r[7:0];
      ADDR_TEMP_HI: rd_data = temp_r[15:8];
      ADDR_HUM_LO: rd_data = hum_r[7:0];
      ADDR_HUM_HI: rd_data = hum_r[15:8];
      ADDR_RESET_INT_CTRL: rd_data = ctrl_r;
      ADDR_MEAS_SETUP: rd_data = setup_r;
      default: rd_data = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Target port state machine
  // ---------------------------------------------------------------
  // Samples on clock rise, changes the line on clock fall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_r <= IS_IDLE;
      shift_r <= 8'h00;
      bitcnt_r <= 4'h0;
      is_addr_r <= 1'b0;
      reading_r <= 1'b0;
      first_wr_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (bus_start) begin
      // Start or repeated start: expect address
      bus_r <= IS_RECV;
      bitcnt_r <= 4'h0;
      is_addr_r <= 1'b1;
      sda_oe_r <= 1'b0;
    end else if (bus_stop) begin
      bus_r <= IS_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (bus_r)
        IS_RECV: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s2_r};
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (scl_fall && bitcnt_r == 4'h8) begin
            if (!is_addr_r) begin
              // Data byte: acknowledge, pointer taken at most once
              first_wr_r <= 1'b0;
              sda_oe_r <= 1'b1;
              bus_r <= IS_ACK;
            end else if (shift_r[7:1] == TARGET_ADDR) begin
              reading_r <= shift_r[0];
              first_wr_r <= 1'b1;
              sda_oe_r <= 1'b1;
              bus_r <= IS_ACK;
            end else begin
              bus_r <= IS_IDLE; // Not ours
            end
          end
        end
        IS_ACK: begin
          if (scl_fall) begin
            is_addr_r <= 1'b0;
            if (reading_r) begin
              // Load next byte and drive its top bit
              shift_r <= rd_data;
              sda_oe_r <= !rd_data[7];
              bitcnt_r <= 4'h1;
              bus_r <= IS_SEND;
            end else begin
              sda_oe_r <= 1'b0;
              bitcnt_r <= 4'h0;
              bus_r <= IS_RECV;
            end
          end
        end
        IS_SEND: begin
          if (scl_fall) begin
            if (bitcnt_r == 4'h8) begin
              sda_oe_r <= 1'b0;
              bus_r <= IS_HOST_ACK;
            end else begin
              sda_oe_r <= !shift_r[6];
              shift_r <= {shift_r[6:0], 1'b0};
              bitcnt_r <= bitcnt_r + 4'h1;
            end
          end
        end
        IS_HOST_ACK: begin
          // Host ack continues the burst, nack ends it
          if (scl_rise) begin
            bus_r <= sda_s2_r ? IS_IDLE : IS_ACK;
          end
        end
        default: bus_r <= IS_IDLE;
      endcase
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_r;

  // ---------------------------------------------------------------
  // Register pointer
  // ---------------------------------------------------------------
  // Loaded by the first written byte, stepped after every later data byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_r <= 8'h00;
    end else if (wr_byte && first_wr_r) begin
      ptr_r <= shift_r;
    end else if (reg_wr || tx_load) begin
      ptr_r <= ptr_r + 8'h01;
    end
  end

  AST_PTR_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    tx_load |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("pointer did not step after a read byte");
  AST_READ_SOURCE: assert property (@(posedge clk) disable iff (!rst_n)
    tx_load && ptr_r == ADDR_HUM_HI |=> shift_r == hum_r[15:8])
    else $error("read byte not taken from pointed register");

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Restart pulse follows a write of the restart bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      restart_r <= 1'b0;
    end else if (ce) begin
      restart_r <= reg_wr && ptr_r == ADDR_RESET_INT_CTRL && shift_r[BIT_RESTART];
    end
  end

  // Control register; restart reloads defaults and clears itself
  always_ff @(posedge clk) begin
    if (!rst_n || (ce && restart_r)) begin
      ctrl_r <= CTRL_RESET;
    end else if (reg_wr && ptr_r == ADDR_RESET_INT_CTRL) begin
      ctrl_r <= shift_r;
    end
  end

  // Setup register; start bit dropped when a one-shot finishes
  always_ff @(posedge clk) begin
    if (!rst_n || (ce && restart_r)) begin
      setup_r <= SETUP_RESET;
    end else if (reg_wr && ptr_r == ADDR_MEAS_SETUP) begin
      setup_r <= shift_r;
    end else if (done_ok && !periodic) begin
      setup_r[BIT_START] <= 1'b0;
    end
  end

  AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
    ce && restart_r |=> ctrl_r == CTRL_RESET && setup_r == SETUP_RESET)
    else $error("restart did not reload defaults");

  assign heater_enable = ctrl_r[BIT_HEAT_EN];

  // ---------------------------------------------------------------
  // Conversion sequencing
  // ---------------------------------------------------------------
  assign rate = ctrl_r[RATE_MSB:RATE_LSB];
  assign periodic = rate != RATE_ONE_SHOT;
  assign start_conv = ce && !restart_r && cs_r == CS_SLEEP && setup_r[BIT_START] &&
                      (!periodic || timer_r == 32'h0);
  assign done_ok = ce && !restart_r && cs_r == CS_MEASURE && conv_done;

  // Sleep until triggered, measure until converter reports
  always_ff @(posedge clk) begin
    if (!rst_n || (ce && restart_r)) begin
      cs_r <= CS_SLEEP;
    end else if (start_conv) begin
      cs_r <= CS_MEASURE;
    end else if (done_ok) begin
      cs_r <= CS_SLEEP;
    end
  end

  // Periodic countdown: first conversion at once, then every period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_r <= 32'h0;
    end else if (ce) begin
      if (!periodic || !setup_r[BIT_START] || restart_r) begin
        timer_r <= 32'h0;
      end else if (start_conv) begin
        timer_r <= rate_cycles(rate) - 32'h1;
      end else if (timer_r != 32'h0) begin
        timer_r <= timer_r - 32'h1;
      end
    end
  end

  // Converter start pulse and channel selection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conv_start_r <= 1'b0;
      conv_temp_en <= 1'b0;
      conv_hum_en <= 1'b0;
    end else if (ce) begin
      conv_start_r <= start_conv;
      conv_temp_en <= setup_r[MODE_MSB:MODE_LSB] != MEAS_HUM_ONLY;
      conv_hum_en <= setup_r[MODE_MSB:MODE_LSB] != MEAS_TEMP_ONLY;
    end
  end
  assign conv_start = conv_start_r;

  AST_SLEEP_AT_RESET: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> cs_r == CS_SLEEP && !conv_start_r)
    else $error("not asleep after reset");
  AST_ONE_SHOT_ONCE: assert property (@(posedge clk) disable iff (!rst_n)
    done_ok && !periodic && !reg_wr |=> cs_r == CS_SLEEP && !setup_r[BIT_START])
    else $error("one-shot did not return to sleep");
  AST_PERIOD_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
    start_conv && periodic && !reg_wr |=> timer_r == rate_cycles($past(rate)) - 32'h1)
    else $error("periodic timer not loaded from rate");
  AST_NO_SELF_START: assert property (@(posedge clk) disable iff (!rst_n)
    cs_r == CS_SLEEP && !setup_r[BIT_START] |-> !start_conv)
    else $error("conversion started without trigger");

  // ---------------------------------------------------------------
  // Result registers
  // ---------------------------------------------------------------
  // Unsigned codes, high byte over low, two low bits zero
  always_ff @(posedge clk) begin
    if (!rst_n || (ce && restart_r)) begin
      temp_r <= 16'h0000;
      hum_r <= 16'h0000;
    end else if (done_ok) begin
      if (conv_temp_en) begin
        temp_r <= shape(conv_temp_code, setup_r[TRES_MSB:TRES_LSB]);
      end
      if (conv_hum_en) begin
        hum_r <= shape(conv_hum_code, setup_r[HRES_MSB:HRES_LSB]);
      end
    end
  end

  AST_LOW_BITS: assert property (@(posedge clk) disable iff (!rst_n)
    temp_r[1:0] == 2'h0 && hum_r[1:0] == 2'h0)
    else $error("reserved result bits not zero");

  // ---------------------------------------------------------------
  // Ready and alarm flags, shared pin
  // ---------------------------------------------------------------
  assign result_read = tx_load && ptr_r <= ADDR_HUM_HI;
  assign over = alarm_enable && (temp_r > temp_alarm_limit || hum_r > hum_alarm_limit);

  // Flags raised one cycle after results land; a set beats a read
  always_ff @(posedge clk) begin
    if (!rst_n || (ce && restart_r)) begin
      update_r <= 1'b0;
      ready_flag_r <= 1'b0;
      alarm_flag_r <= 1'b0;
    end else if (ce) begin
      update_r <= done_ok;
      if (update_r) begin
        ready_flag_r <= 1'b1;
      end else if (result_read) begin
        ready_flag_r <= 1'b0;
      end
      if (update_r && over) begin
        alarm_flag_r <= 1'b1;
      end else if (result_read) begin
        alarm_flag_r <= 1'b0;
      end
    end
  end

  // Pin: sticky sources or live comparison, then polarity
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_r <= 1'b0;
    end else if (ce) begin
      pin_r <= (ctrl_r[BIT_PIN_EN] && (ready_flag_r ||
               (ctrl_r[BIT_PIN_MODE] ? over : alarm_flag_r))) == ctrl_r[BIT_PIN_POL];
    end
  end
  assign ready_alarm_pin = pin_r;

  AST_READY_AFTER_DATA: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ready_flag_r) |-> $past(update_r) && $past(done_ok, 2))
    else $error("ready raised before results stored");
  AST_PIN_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !ctrl_r[BIT_PIN_EN] && !restart_r && !reg_wr [*2] |->
    ready_alarm_pin == !ctrl_r[BIT_PIN_POL])
    else $error("disabled pin not at inactive level");
  AST_ALARM_PIN: assert property (@(posedge clk) disable iff (!rst_n)
    ce && ctrl_r[BIT_PIN_EN] && ctrl_r[BIT_PIN_POL] && !ctrl_r[BIT_PIN_MODE] && alarm_flag_r &&
    !restart_r && !reg_wr
    |=> ready_alarm_pin)
    else $error("alarm not shown on pin");
endmodule

// [pkg/acq_pkg.sv]
// Constants, field layout and types for the humidity/temperature acquisition control
package acq_pkg;
  // ---------------------------------------------------------------
  // Register addresses seen through the bus pointer
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_TEMP_LO = 8'h00;
  localparam logic [7:0] ADDR_TEMP_HI = 8'h01;
  localparam logic [7:0] ADDR_HUM_LO = 8'h02;
  localparam logic [7:0] ADDR_HUM_HI = 8'h03;
  localparam logic [7:0] ADDR_RESET_INT_CTRL = 8'h0E;
  localparam logic [7:0] ADDR_MEAS_SETUP = 8'h0F;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_RESTART = 7;     // software_restart_bit
  localparam int RATE_MSB = 6;        // periodic_rate_select
  localparam int RATE_LSB = 4;
  localparam int BIT_HEAT_EN = 3;
  localparam int BIT_PIN_EN = 2;
  localparam int BIT_PIN_POL = 1;
  localparam int BIT_PIN_MODE = 0;
  localparam int TRES_MSB = 7;
  localparam int TRES_LSB = 6;
  localparam int HRES_MSB = 5;
  localparam int HRES_LSB = 4;
  localparam int MODE_MSB = 2;
  localparam int MODE_LSB = 1;
  localparam int BIT_START = 0;       // conversion_start_bit
  // ---------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [2:0] RATE_ONE_SHOT = 3'h0;
  localparam logic [1:0] RES_14 = 2'h0;
  localparam logic [1:0] RES_11 = 2'h1;
  localparam logic [1:0] RES_9 = 2'h2;
  localparam logic [1:0] MEAS_TEMP_ONLY = 2'h1;
  localparam logic [1:0] MEAS_HUM_ONLY = 2'h2;
  localparam int CODE_W = 14;
  localparam int NUM_RATES = 7;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_KHZ = 20000;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic {CS_SLEEP, CS_MEASURE} conv_state_t;
  typedef enum logic [2:0] {IS_IDLE, IS_RECV, IS_ACK, IS_SEND, IS_HOST_ACK} bus_state_t;
endpackage

// [tb/bus_host_model.sv]
// Bus host model: directly driven clock and open-drain data driver for the register port
`timescale 1ns/100ps
module bus_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h40,
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl_line,
  output logic sda_pull
);
  // ---------------------------------------------------------------
  // Line primitives; released lines float high on their pull-ups
  // ---------------------------------------------------------------
  initial begin
    scl_line = 1'b1;
    sda_pull = 1'b0;
  end

  // Step n edges, then just past the edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Start (stp low) or stop (stp high), data moving while clock is high
  task automatic cond(input logic stp);
    sda_pull = stp;
    wt(HALF);
    scl_line = 1'b1;
    wt(HALF);
    sda_pull = !stp;
    wt(HALF);
    if (!stp) begin
      scl_line = 1'b0;
      wt(2);
    end
  endtask

  // One bit slot: drive or release data, sample late in the high phase
  task automatic bit_c(input logic b, output logic got);
    sda_pull = !b;
    wt(HALF);
    scl_line = 1'b1;
    wt(HALF);
    got = sda_line;
    scl_line = 1'b0;
    wt(2);
  endtask

  // Byte plus acknowledge slot; ack_in high means not acknowledged
  task automatic byte_c(input logic [7:0] wb, input logic ack_out,
                        output logic [7:0] rb, output logic ack_in);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_c(wb[i], g);
      rb[i] = g;
    end
    bit_c(ack_out, ack_in);
  endtask

  // Start, address with write bit, then the pointer byte
  task automatic head(input logic [6:0] dev, input logic [7:0] ptr, output logic nack);
    logic [7:0] rb;
    logic a;
    cond(1'b0);
    byte_c({dev, 1'b0}, 1'b1, rb, nack);
    byte_c(ptr, 1'b1, rb, a);
    nack = nack | a;
  endtask

  // Register write: one data byte at the pointer
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                    output logic nack);
    logic [7:0] rb;
    logic a;
    head(dev, ptr, nack);
    byte_c(d, 1'b1, rb, a);
    nack = nack | a;
    cond(1'b1);
  endtask

  // Burst read of n bytes after a repeated start; the last byte is refused
  task automatic rd(input logic [7:0] ptr, input int n, output logic [31:0] data);
    logic [7:0] rb;
    logic a;
    data = 32'h0;
    head(DEV_ADDR, ptr, a);
    cond(1'b0);
    byte_c({DEV_ADDR, 1'b1}, 1'b1, rb, a);
    for (int k = 0; k < n; k++) begin
      byte_c(8'hFF, k == n - 1, rb, a);
      data[8*k+:8] = rb;
    end
    cond(1'b1);
  endtask
endmodule

// [tb/humidity_temp_acquisition_ctrl_tb_top.sv]
// Testbench top: register port, converter stub and ready/alarm pin checks
`timescale 1ns/100ps
module humidity_temp_acquisition_ctrl_tb_top
  import acq_pkg::*;
;
  // Shortened periods: every rate is 1 ms
  localparam int unsigned RMS [1:NUM_RATES] = '{1, 1, 1, 1, 1, 1, 1};
  logic clk;
  logic rst_n;
  logic scl_line, sda_pull, sda_line, sda_o, sda_oe, pin, heat;
  logic conv_start, temp_en, hum_en;
  logic conv_done;
  logic ce;                            // Clock enable, dropped in the freeze check
  logic [CODE_W-1:0] tc, hc;           // Converter codes
  logic alarm_en;
  logic [15:0] t_lim, h_lim;           // Alarm limits
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int starts = 0;
  int last_start = 0;
  int last_gap = 0;
  int cd = 0;
  int base;
  logic n;
  logic [31:0] d;

  // Open-drain data wire with pull-up
  assign sda_line = !(sda_pull | (sda_oe & !sda_o));

  humidity_temp_acquisition_ctrl #(.TARGET_ADDR(7'h40), .RATE_MS(RMS)) dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .scl_i(scl_line), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .ready_alarm_pin(pin), .heater_enable(heat),
    .conv_start(conv_start), .conv_temp_en(temp_en), .conv_hum_en(hum_en),
    .conv_done(conv_done), .conv_temp_code(tc), .conv_hum_code(hc),
    .alarm_enable(alarm_en), .temp_alarm_limit(t_lim), .hum_alarm_limit(h_lim)
  );
  bus_host_model #(.DEV_ADDR(7'h40), .HALF(8)) host (
    .clk(clk), .sda_line(sda_line), .scl_line(scl_line), .sda_pull(sda_pull)
  );

  // ---------------------------------------------------------------
  // Clock, converter stub, timeout
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Converter answers 100 cycles after each start; starts and gaps counted
  always @(posedge clk) begin
    cyc <= cyc + 1;
    conv_done <= (cd == 1);
    if (cd > 0) begin
      cd <= cd - 1;
    end
    if (conv_start === 1'b1) begin
      cd <= 100;
      starts <= starts + 1;
      last_gap <= cyc - last_start;
      last_start <= cyc;
    end
  end

  initial begin
    wait (cyc >= 95000);
    miscompares++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Register write; the target must acknowledge every byte
  task automatic w(input logic [7:0] a, input logic [7:0] v);
    host.wr(7'h40, a, v, n);
    check("write ack", n, 1'b0);
  endtask

  // Bounded wait for a pin level
  task automatic wait_pin(input logic v);
    for (int i = 0; i < 5000 && pin !== v; i++) begin
      host.wt(1);
    end
    check("pin level", pin, v);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    check("starts idle", starts, 32'h0);
    check("pin idle", pin, 1'b1);
    host.rd(ADDR_RESET_INT_CTRL, 2, d);
    check("config reset", d, {16'h0, SETUP_RESET, CTRL_RESET});
    host.rd(ADDR_TEMP_LO, 4, d);
    check("results reset", d, 32'h0);
  endtask

  task automatic test_one_shot();
    tc = 14'h1234;
    hc = 14'h2ABC;
    w(ADDR_RESET_INT_CTRL, 8'h06);
    w(ADDR_MEAS_SETUP, 8'h01);
    check("pin while busy", pin, 1'b0);
    check("both enabled", {temp_en, hum_en}, 2'b11);
    wait_pin(1'b1);
    host.rd(ADDR_TEMP_LO, 4, d);
    check("results", d, {hc, 2'b00, tc, 2'b00});
    check("celsius", ((d[15:0] * 165) >> 16) - 40, 32'd6);
    check("percent", (d[31:16] * 100) >> 16, 32'd66);
    check("ready cleared", pin, 1'b0);
    host.rd(ADDR_MEAS_SETUP, 1, d);
    check("start cleared", d, 32'h0);
    host.wt(2000);
    check("single start", starts, 32'h1);
  endtask

  task automatic test_alarm();
    alarm_en = 1'b1;
    t_lim = 16'h1000;
    tc = 14'h3007;
    w(ADDR_RESET_INT_CTRL, 8'h06);
    w(ADDR_MEAS_SETUP, 8'h43);
    check("temp only", {temp_en, hum_en}, 2'b10);
    host.wt(300);
    check("sticky alarm", pin, 1'b1);
    host.rd(ADDR_TEMP_LO, 2, d);
    check("temp result", d, {16'h0, tc[13:3], 3'h0, 2'b00});
    check("alarm cleared", pin, 1'b0);
    w(ADDR_RESET_INT_CTRL, 8'h07);
    check("live alarm", pin, 1'b1);
    w(ADDR_RESET_INT_CTRL, 8'h05);
    check("alarm active low", pin, 1'b0);
    t_lim = 16'hFFFF;
    host.wt(6);
    check("alarm gone", pin, 1'b1);
    h_lim = 16'h1000;
    host.wt(6);
    check("hum alarm", pin, 1'b0);
    h_lim = 16'hFFFF;
    alarm_en = 1'b0;
  endtask

  task automatic test_periodic();
    w(ADDR_RESET_INT_CTRL, 8'h70);
    base = starts;
    w(ADDR_MEAS_SETUP, 8'h21);
    for (int i = 0; i < 50000 && starts < base + 3; i++) begin
      host.wt(1);
    end
    check("periodic count", starts, base + 3);
    check("period", last_gap, RMS[7] * 20000);
    host.rd(ADDR_HUM_LO, 2, d);
    check("hum 9 bit", d, {16'h0, hc[13:5], 5'h00, 2'b00});
    w(ADDR_MEAS_SETUP, 8'h00);
    base = starts;
    host.wt(21000);
    check("stopped", starts, base);
  endtask

  task automatic test_restart();
    w(ADDR_RESET_INT_CTRL, 8'h0E);
    check("heater on", heat, 1'b1);
    w(ADDR_RESET_INT_CTRL, 8'h80);
    host.rd(ADDR_RESET_INT_CTRL, 2, d);
    check("defaults", d, {16'h0, SETUP_RESET, CTRL_RESET});
    check("heater off", heat, 1'b0);
    host.rd(ADDR_TEMP_LO, 4, d);
    check("results cleared", d, 32'h0);
    host.wr(7'h41, ADDR_MEAS_SETUP, 8'h01, n);
    check("foreign address", n, 1'b1);
    host.wt(300);
    check("no foreign start", starts, base);
    host.rd(8'h20, 1, d);
    check("unmapped", d, 32'h0);
    // Frozen block must ignore a trigger write
    ce = 1'b0;
    host.wr(7'h40, ADDR_MEAS_SETUP, 8'h01, n);
    ce = 1'b1;
    check("frozen ack", n, 1'b1);
    host.wt(300);
    check("frozen start", starts, base);
  endtask

  // Reset for 3 cycles, then the scenarios in order
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    tc = 14'h0;
    hc = 14'h0;
    alarm_en = 1'b0;
    t_lim = 16'hFFFF;
    h_lim = 16'hFFFF;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    host.wt(200);
    test_reset();
    test_one_shot();
    test_alarm();
    test_periodic();
    test_restart();
    finish_test();
  end
endmodule
